// ### design/rst_pfd.sv
// reset sequencing between power-on and enable-pin reset, with the
// carry-disable flip-flop used for power-failure detection
// assumes detector, enable pin and carry pulse are synchronous levels
`timescale 1ns/100ps
// Summary of operation
// - simultaneous rise gives one power-on start
// - enable during forced halt: single start only
// - enable after release: restart on carry edge
// - enable reset leaves stop, threshold after 50ms
// - supply low sets disable, flag read clears
// - disable flip-flop blocks carry flag setting
// - power-on start with carry flag cleared until read
// - flag set each carry pulse rising edge
// - reading the carry flag clears it
// - fail threshold equals power-on threshold
// - enable reset aborts routine at carry edge
// - period change may fire pending reset
// - supply release halts until carry edge
module rst_pfd
    import rst_pfd_pkg::*;
#(
    parameter int unsigned HOLD_CYC = THR_HOLD_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // supply detector and enable pin
    input  wire logic supply_low_detect,
    input  wire logic chip_enable,
    input  wire logic clock_stop,
    // carry setting pulse from timer divider
    input  wire logic carry_set_pulse,
    // cpu side
    input  wire logic flag_read,
    output logic      timer_carry_flag,
    output logic      carry_disable,
    output logic      cpu_halt,
    output logic      cpu_restart,
    output logic [15:0] restart_addr,
    output logic      thr_sel
);
    import rst_pfd_pkg::*;

    seq_state_t  state_r;
    logic        carry_edge;
    logic        ce_edge;
    logic        ce_pend_r;
    logic        flag_r;
    logic        dis_r;
    logic        halt_r;
    logic        rst_pulse_r;
    logic        thr_r;
    logic        thr_cnt_run_r;
    logic [31:0] thr_cnt_r;

    // edges of the carry pulse and the enable pin
    rise_det u_carry_edge (
        .clk  (clk),
        .nrst (nrst),
        .lvl  (carry_set_pulse),
        .rise (carry_edge)
    );
    rise_det u_ce_edge (
        .clk  (clk),
        .nrst (nrst),
        .lvl  (chip_enable),
        .rise (ce_edge)
    );

    // reset sequencer; the timer divider itself lives outside and is
    // reinitialised to its 100 ms period by our restart pulse
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r     <= ST_OFF;
            halt_r      <= 1'b1;
            rst_pulse_r <= 1'b0;
            ce_pend_r   <= 1'b0;
        end else begin
            rst_pulse_r <= 1'b0;
            case (state_r)
                ST_OFF: begin
                    halt_r    <= 1'b1;
                    ce_pend_r <= 1'b0;
                    if (!supply_low_detect) begin
                        state_r <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    // enable edges here merge into the power-on start
                    ce_pend_r <= 1'b0;
                    if (supply_low_detect) begin
                        state_r <= ST_OFF;
                    end else if (carry_edge) begin
                        state_r     <= ST_RUN;
                        halt_r      <= 1'b0;
                        rst_pulse_r <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (supply_low_detect) begin
                        state_r <= ST_OFF;
                        halt_r  <= 1'b1;
                    end else if (carry_edge && (ce_pend_r || ce_edge)) begin
                        // routine aborted without waiting for its end
                        rst_pulse_r <= 1'b1;
                        ce_pend_r   <= 1'b0;
                    end else if (ce_edge) begin
                        // an enable edge only sets the pending flag; the
                        // next carry edge, early after a period change, fires it
                        ce_pend_r <= 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_OFF;
                end
            endcase
        end
    end

    // carry-disable flip-flop; detector set wins over read clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dis_r <= 1'b1;
        end else if (supply_low_detect) begin
            dis_r <= 1'b1;
        end else if (flag_read) begin
            dis_r <= 1'b0;
        end
    end

    // carry flag; a carry edge in the read cycle is not lost
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_r <= 1'b0;
        end else if (supply_low_detect) begin
            flag_r <= 1'b0;
        end else if (carry_edge && !dis_r) begin
            flag_r <= 1'b1;
        end else if (flag_read) begin
            flag_r <= 1'b0;
        end
    end

    // threshold select: stop level held until 50 ms after enable rise
    always_ff @(posedge clk) begin
        if (!nrst) begin
            thr_r         <= THR_RUN;
            thr_cnt_run_r <= 1'b0;
            thr_cnt_r     <= '0;
        end else if (clock_stop && !thr_cnt_run_r) begin
            thr_r <= THR_STOP;
            if (ce_edge) begin
                thr_cnt_run_r <= 1'b1;
                thr_cnt_r     <= '0;
            end
        end else if (thr_cnt_run_r) begin
            if (thr_cnt_r == HOLD_CYC - 1) begin
                thr_r         <= THR_RUN;
                thr_cnt_run_r <= 1'b0;
            end else begin
                thr_cnt_r <= thr_cnt_r + 32'h1;
            end
        end else begin
            thr_r <= THR_RUN;
        end
    end

    assign timer_carry_flag = flag_r;
    assign carry_disable    = dis_r;
    assign cpu_halt         = halt_r;
    assign cpu_restart      = rst_pulse_r;
    assign restart_addr     = START_ADDR;
    assign thr_sel          = thr_r;

    // flag and disable flip-flop behaviour
    AST_DIS_BLOCKS: assert property (@(posedge clk) disable iff (!nrst)
        dis_r |=> !($rose(flag_r)))
        else $error("carry flag set while disabled");
    AST_LOW_SETS_DIS: assert property (@(posedge clk)
        disable iff (!nrst) supply_low_detect |=> dis_r && !flag_r)
        else $error("supply low did not set disable");
    AST_READ_CLEARS: assert property (@(posedge clk)
        disable iff (!nrst)
        flag_read && !carry_edge && !supply_low_detect |=> !flag_r)
        else $error("read did not clear flag");
    AST_CARRY_SETS: assert property (@(posedge clk) disable iff (!nrst)
        carry_edge && !dis_r && !supply_low_detect |=> flag_r)
        else $error("carry edge did not set flag");
    // reset sequencing
    AST_HALT_RELEASE: assert property (@(posedge clk)
        disable iff (!nrst)
        state_r == ST_HALT && carry_edge && !supply_low_detect
        |=> cpu_restart && !cpu_halt)
        else $error("halt not released on carry edge");
    AST_NO_EXTRA: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_HALT |=> !ce_pend_r)
        else $error("enable reset pending after halt");
    AST_CE_RESTART: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_RUN && ce_pend_r && carry_edge && !supply_low_detect
        |=> cpu_restart)
        else $error("enable restart missed");
    AST_RESTART_EDGE: assert property (@(posedge clk)
        disable iff (!nrst) cpu_restart |-> $past(carry_edge))
        else $error("restart off carry edge");
    // restart is a single pulse, never repeated by itself
    AST_ONE_PULSE: assert property (@(posedge clk)
        disable iff (!nrst) cpu_restart |=> !cpu_restart)
        else $error("restart pulse longer than one cycle");
    // without a pending enable reset the running cpu is left alone
    AST_RUN_QUIET: assert property (@(posedge clk)
        disable iff (!nrst)
        state_r == ST_RUN && !ce_pend_r && !ce_edge |=> !cpu_restart)
        else $error("restart without enable reset");
    // supply low stops the cpu whatever the enable pin does
    AST_LOW_HALTS: assert property (@(posedge clk)
        disable iff (!nrst) supply_low_detect |=> cpu_halt && !cpu_restart)
        else $error("cpu not halted on supply low");
    // threshold select
    AST_THR_STOP: assert property (@(posedge clk)
        disable iff (!nrst)
        clock_stop && !thr_cnt_run_r |=> thr_sel == THR_STOP)
        else $error("stop threshold not selected");
    AST_THR_BACK: assert property (@(posedge clk) disable iff (!nrst)
        thr_cnt_run_r && thr_cnt_r == HOLD_CYC - 1 |=> thr_sel == THR_RUN)
        else $error("threshold not restored");
endmodule : rst_pfd

// ### design/rst_pfd_pkg.sv
// constants for the reset source and power-fail detect logic
// assumes a single 20 MHz clock and synchronous inputs
package rst_pfd_pkg;
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned THR_HOLD_MS    = 50;
    localparam int unsigned THR_HOLD_CYC   = CLK_HZ / 1000 * THR_HOLD_MS;
    localparam int unsigned INIT_PERIOD_MS = 100;
    localparam logic [15:0] START_ADDR     = 16'h0000;
    // supply-low threshold select encoding
    localparam logic        THR_RUN        = 1'b0; // 3.5 V level
    localparam logic        THR_STOP       = 1'b1; // 2.3 V level
    typedef enum logic [1:0] {ST_OFF, ST_HALT, ST_RUN} seq_state_t;
endpackage : rst_pfd_pkg

// ### design/rise_det.sv
// rising edge detector for a synchronous level
// assumes the input is already in the clk domain
`timescale 1ns/100ps
module rise_det (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // level in, pulse out
    input  wire logic lvl,
    output logic      rise
);
    logic lvl_r;

    // delayed copy for edge compare
    always_ff @(posedge clk) begin
        if (!nrst) begin
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= lvl;
        end
    end

    assign rise = lvl & ~lvl_r;
endmodule : rise_det

// ### verif/cpu_model.sv
// cpu model: after each restart it reads the carry flag once and keeps
// the value read as the reset class (0 power failure, 1 enable reset)
// assumes restart is a one-cycle pulse and the bench may add reads
`timescale 1ns/100ps
module cpu_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // device side
    input  wire logic cpu_restart,
    input  wire logic timer_carry_flag,
    output logic      flag_read,
    // bench side
    input  wire logic ext_read,
    output logic      last_class,
    output int        restarts
);
    logic [1:0] cnt_r;
    logic       own_read_r;

    // read soon after the start, well before the next carry edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r      <= 2'h0;
            own_read_r <= 1'b0;
            last_class <= 1'b0;
            restarts   <= 0;
        end else begin
            own_read_r <= (cnt_r == 2'h1);
            if (cnt_r == 2'h1)
                last_class <= timer_carry_flag;
            if (cpu_restart) begin
                // short init, done well inside one carry period
                cnt_r    <= 2'h3;
                restarts <= restarts + 1;
            end else if (cnt_r != 2'h0)
                cnt_r <= cnt_r - 2'h1;
        end
    end

    // own pulse and bench pulse share the read strobe
    assign flag_read = own_read_r | ext_read;
endmodule : cpu_model

// ### verif/tb.sv
// bench for the reset source and power-fail detect block
// assumes the cpu model file is compiled first; short hold count
`timescale 1ns/100ps
module tb;
    import rst_pfd_pkg::*;
    localparam int unsigned HOLD = 20;
    logic        clk, nrst, supply_low_detect, chip_enable, clock_stop;
    logic        carry_set_pulse, ext_read, flag_read, timer_carry_flag;
    logic        carry_disable, cpu_halt, cpu_restart, thr_sel, last_class;
    logic [15:0] restart_addr;
    int          err_total, checks, restarts;

    rst_pfd #(.HOLD_CYC(HOLD)) uut (.clk(clk), .nrst(nrst),
        .supply_low_detect(supply_low_detect), .chip_enable(chip_enable),
        .clock_stop(clock_stop), .carry_set_pulse(carry_set_pulse),
        .flag_read(flag_read), .timer_carry_flag(timer_carry_flag),
        .carry_disable(carry_disable), .cpu_halt(cpu_halt),
        .cpu_restart(cpu_restart), .restart_addr(restart_addr),
        .thr_sel(thr_sel));
    cpu_model cpu (.clk(clk), .nrst(nrst), .cpu_restart(cpu_restart),
        .timer_carry_flag(timer_carry_flag), .flag_read(flag_read),
        .ext_read(ext_read), .last_class(last_class), .restarts(restarts));

    // 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // inputs always move 5 ns after the edge
    task step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : step
    // one carry pulse, long enough for the model's read to land
    task carry;
        carry_set_pulse = 1'b1;
        step(2);
        carry_set_pulse = 1'b0;
        step(8);
    endtask : carry
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task final_report;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    initial begin
        {nrst, chip_enable, clock_stop, carry_set_pulse, ext_read} = 5'h00;
        supply_low_detect = 1'b1;
        err_total = 0;
        checks = 0;
        step(16);
        nrst = 1'b1;
        step(1);
        chk("flag", timer_carry_flag, 16'h0000);
        chk("dis", carry_disable, 16'h0001);
        chk("halt", cpu_halt, 16'h0001);
        chk("thr", thr_sel, 16'h0000);
        // supply and enable rise together: one start
        supply_low_detect = 1'b0;
        chip_enable = 1'b1;
        step(3);
        chk("halt", cpu_halt, 16'h0001);
        carry;
        chk("halt", cpu_halt, 16'h0000);
        chk("restarts", restarts[15:0], 16'h0001);
        chk("addr", restart_addr, 16'h0000);
        chk("class", last_class, 16'h0000);
        chk("dis", carry_disable, 16'h0000);
        carry;
        chk("flag", timer_carry_flag, 16'h0001);
        ext_read = 1'b1;
        step(1);
        ext_read = 1'b0;
        step(1);
        chk("flag", timer_carry_flag, 16'h0000);
        // enable rise while running pends until the carry edge
        chip_enable = 1'b0;
        step(2);
        chip_enable = 1'b1;
        step(4);
        chk("restarts", restarts[15:0], 16'h0001);
        carry;
        chk("restarts", restarts[15:0], 16'h0002);
        chk("class", last_class, 16'h0001);
        // supply low sets disable, carry cannot set the flag
        supply_low_detect = 1'b1;
        chip_enable = 1'b0;
        step(2);
        chk("dis", carry_disable, 16'h0001);
        carry;
        chk("flag", timer_carry_flag, 16'h0000);
        // enable rise during the forced halt gives one start only
        supply_low_detect = 1'b0;
        step(2);
        chip_enable = 1'b1;
        step(2);
        carry;
        carry;
        chk("restarts", restarts[15:0], 16'h0003);
        chk("class", last_class, 16'h0000);
        // clock stop: low threshold until hold after enable rise; the
        // stop state lasts until the enable edge has been taken
        clock_stop = 1'b1;
        chip_enable = 1'b0;
        step(3);
        chk("thr", thr_sel, 16'h0001);
        chip_enable = 1'b1;
        step(1);
        clock_stop = 1'b0;
        step(HOLD - 1);
        chk("thr", thr_sel, 16'h0001);
        step(1);
        chk("thr", thr_sel, 16'h0000);
        carry;
        chk("restarts", restarts[15:0], 16'h0004);
        // enable edge in the same cycle as a carry edge fires at once
        chip_enable = 1'b0;
        step(2);
        chip_enable = 1'b1;
        carry;
        chk("restarts", restarts[15:0], 16'h0005);
        chk("class", last_class, 16'h0001);
        final_report;
    end
endmodule : tb
